// >>> design/uafc_pkg.sv
// Package of constants and carrier types for the UART auto flow control block
package uafc_pkg;

    // ************************************************************
    // Register byte offsets on APB
    // ************************************************************
    localparam logic [7:0] OFF_ENH_FEATURE = 8'h00;
    localparam logic [7:0] OFF_INT_ENABLE  = 8'h04;
    localparam logic [7:0] OFF_MODEM_CTRL  = 8'h08;
    localparam logic [7:0] OFF_LINE_CTRL   = 8'h0C;
    localparam logic [7:0] OFF_XON1        = 8'h10;
    localparam logic [7:0] OFF_XON2        = 8'h14;
    localparam logic [7:0] OFF_XOFF1       = 8'h18;
    localparam logic [7:0] OFF_XOFF2       = 8'h1C;
    localparam logic [7:0] OFF_INT_STATUS  = 8'h20;
    localparam logic [7:0] OFF_FIFO_CTRL   = 8'h24;
    localparam logic [7:0] OFF_FLOW_STATE  = 8'h28;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int EFR_SW_LO    = 0;  // Software flow mode, bits 3:0
    localparam int EFR_ENH_EN   = 4;
    localparam int EFR_SPECIAL  = 5;
    localparam int EFR_AUTO_RTS = 6;
    localparam int EFR_AUTO_CTS = 7;
    localparam int IER_XOFF     = 5;
    localparam int IER_RTS      = 6;
    localparam int IER_CTS      = 7;
    localparam int MCR_RTS      = 1;
    localparam int MCR_LOOP     = 4;
    localparam int ISR_XOFF_SP  = 4;
    localparam int ISR_RTS_CTS  = 5;
    localparam int FCR_TRIG_LO  = 0;  // Trigger select, bits 1:0
    localparam int FCR_AUTO_XO  = 2;  // Automatic Xoff/Xon sending

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam int         CHAR_BITS_TIME = 10;  // Bits per character
    localparam int         BIT_TICKS      = 16;  // 16X clocks per bit
    localparam int         XOFF_DELAY_CYC = 2 * CHAR_BITS_TIME * BIT_TICKS;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } uafc_char_t;

    typedef struct packed {
        logic       req;
        logic [7:0] data;
    } uafc_txreq_t;

    typedef enum logic [1:0] {
        SEND_IDLE  = 2'b00,
        SEND_WAIT  = 2'b01,
        SEND_FIRST = 2'b10,
        SEND_SECND = 2'b11
    } uafc_send_t;

endpackage : uafc_pkg

// >>> design/uafc_char_cmp.sv
// Word-length masked character comparator
`timescale 1ns/10ps
`default_nettype none
module uafc_char_cmp
    import uafc_pkg::*;
(
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic [1:0] wlen,
    output logic            eq
);
    logic [7:0] mask;

    // Keep only the low 5 to 8 bits, bit 0 is the first received
    always_comb begin
        unique case (wlen)
            2'b00: mask = 8'h1F;
            2'b01: mask = 8'h3F;
            2'b10: mask = 8'h7F;
            2'b11: mask = 8'hFF;
        endcase
        eq = ((a ^ b) & mask) == 8'h00;
    end
endmodule // uafc_char_cmp
`default_nettype wire

// >>> design/uafc_top.sv
// UART automatic hardware and software flow control with APB registers
//
// Summary of operation
// - Auto RTS control only while enhanced feature bit 6 is set.
// - RTS low-to-high sets status bit 5 and interrupt when enabled.
// - CTS gates transmitter only while enhanced feature bit 7 set.
// - CTS going high sets status bit 5 and interrupt when enabled.
// - CTS high stops transmit after current stop bit, resumes on low.
// - RTS drops at upper fill threshold, returns at lower threshold.
// - Received Xoff character(s) halt transmit after current character.
// - Xoff match sets flag and interrupt when enable bit 5 set.
// - Xon match while suspended resumes transmit, clears status bit 4.
// - Reset clears all Xon and Xoff registers to zero.
// - Double mode needs two consecutive matching characters.
// - Consumed flow control characters never enter the receive FIFO.
// - Auto Xoff sent two character times after trigger crossing.
// - Xon sent when fill drops one level below trigger.
// - Triggers 1,4,8,14 send Xoff there, Xon at 0,1,4,8.
// - Special mode matches Xoff2, stores it, sets status bit 4.
// - Comparisons use only word-length selected low bits.
// - Register bit 0 matches first received character bit.
// - No auto RTS or CTS while internal loopback active.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module uafc_top
    import uafc_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        CTS_N,
    output logic             RTS_N,
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_DATA,
    output logic             FIFO_WR,
    output logic [7:0]       FIFO_WDATA,
    input  wire logic [4:0]  RX_FILL,
    input  wire logic [3:0]  RTS_HI_TH,
    input  wire logic [3:0]  RTS_LO_TH,
    input  wire logic        TX_CHAR_END,
    output logic             TX_ENABLE,
    output logic             FC_TX_REQ,
    output logic [7:0]       FC_TX_DATA,
    input  wire logic        FC_TX_ACK,
    output logic             IRQ
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] efr_r, ier_r, mcr_r, lcr_r, fcr_r;
    logic [7:0] xon1_r, xon2_r, xoff1_r, xoff2_r;
    logic       st_rc_r, st_xo_r;
    logic       cts_m_r, cts_s_r, cts_d_r;
    logic       rts_r, rts_d_r, rts_hold_r;
    logic       cts_stop_r, xoff_stop_r;
    logic       pend_off_r;
    logic [7:0] prev_r;
    logic       prev_on_r, prev_off_r;
    uafc_char_t  rxo_r;
    uafc_txreq_t txo_r;
    uafc_send_t  snd_r;
    logic       snd_xon_r, xoff_sent_r;
    logic [9:0] dly_r;
    logic       ten_r, irq_r;
    logic [31:0] prdata_r;
    logic        pready_r;

    wire wr_en = PSEL & PENABLE & PWRITE & pready_r;
    wire rd_en = PSEL & ~PWRITE & ~PENABLE;
    wire loop  = mcr_r[MCR_LOOP];
    wire a_rts = efr_r[EFR_AUTO_RTS] & ~loop;
    wire a_cts = efr_r[EFR_AUTO_CTS] & ~loop;
    wire dbl_on  = efr_r[1:0] == 2'b11;
    wire dbl_off = efr_r[3:2] == 2'b11;
    wire sw_on   = efr_r[1:0] != 2'b00;
    wire sw_off  = efr_r[3:2] != 2'b00;
    wire [7:0] on_a  = efr_r[0] ? xon1_r  : xon2_r;
    wire [7:0] off_a = efr_r[2] ? xoff1_r : xoff2_r;

    // ************************************************************
    // Comparators
    // ************************************************************
    logic m_on, m_off, m_on2, m_off2, m_on1p, m_off1p, m_sp;
    uafc_char_cmp u_on   (.a(RX_DATA), .b(on_a),    .wlen(lcr_r[1:0]),
                          .eq(m_on));
    uafc_char_cmp u_off  (.a(RX_DATA), .b(off_a),   .wlen(lcr_r[1:0]),
                          .eq(m_off));
    uafc_char_cmp u_on2  (.a(RX_DATA), .b(xon2_r),  .wlen(lcr_r[1:0]),
                          .eq(m_on2));
    uafc_char_cmp u_off2 (.a(RX_DATA), .b(xoff2_r), .wlen(lcr_r[1:0]),
                          .eq(m_off2));
    uafc_char_cmp u_on1p (.a(prev_r),  .b(xon1_r),  .wlen(lcr_r[1:0]),
                          .eq(m_on1p));
    uafc_char_cmp u_of1p (.a(prev_r),  .b(xoff1_r), .wlen(lcr_r[1:0]),
                          .eq(m_off1p));
    assign m_sp = m_off2;

    // Match decisions, single or double character
    wire hit_on  = RX_VALID & sw_on &
                   (dbl_on ? (prev_on_r & m_on1p & m_on2) : m_on);
    wire hit_off = RX_VALID & sw_off &
                   (dbl_off ? (prev_off_r & m_off1p & m_off2) : m_off);
    wire part_on  = RX_VALID & dbl_on  & m_on;
    wire part_off = RX_VALID & dbl_off & m_off;
    wire hit_sp   = RX_VALID & efr_r[EFR_SPECIAL] & m_sp & ~hit_off;
    wire consume  = hit_on | hit_off | part_on | part_off;

    // ************************************************************
    // APB register writes
    // ************************************************************
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            efr_r <= RST_BYTE; ier_r <= RST_BYTE; mcr_r <= RST_BYTE;
            lcr_r <= RST_BYTE; fcr_r <= RST_BYTE;
            xon1_r <= RST_BYTE; xon2_r <= RST_BYTE;
            xoff1_r <= RST_BYTE; xoff2_r <= RST_BYTE;
        end else if (wr_en) begin
            unique case (PADDR)
                OFF_ENH_FEATURE: efr_r <= PWDATA[7:0];
                // Upper enable bits locked until enhanced bit 4 set
                OFF_INT_ENABLE: ier_r <= efr_r[EFR_ENH_EN] ? PWDATA[7:0] :
                                 {ier_r[7:4], PWDATA[3:0]};
                OFF_MODEM_CTRL: mcr_r <= PWDATA[7:0];
                OFF_LINE_CTRL:  lcr_r <= PWDATA[7:0];
                OFF_XON1:       xon1_r <= PWDATA[7:0];
                OFF_XON2:       xon2_r <= PWDATA[7:0];
                OFF_XOFF1:      xoff1_r <= PWDATA[7:0];
                OFF_XOFF2:      xoff2_r <= PWDATA[7:0];
                OFF_FIFO_CTRL:  fcr_r <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // APB read and ready
    // ************************************************************
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
        end else begin
            pready_r <= PSEL & ~PENABLE;
            if (rd_en) begin
                unique case (PADDR)
                    OFF_ENH_FEATURE: prdata_r <= {24'h00_0000, efr_r};
                    OFF_INT_ENABLE:  prdata_r <= {24'h00_0000, ier_r};
                    OFF_MODEM_CTRL:  prdata_r <= {24'h00_0000, mcr_r};
                    OFF_LINE_CTRL:   prdata_r <= {24'h00_0000, lcr_r};
                    OFF_XON1:        prdata_r <= {24'h00_0000, xon1_r};
                    OFF_XON2:        prdata_r <= {24'h00_0000, xon2_r};
                    OFF_XOFF1:       prdata_r <= {24'h00_0000, xoff1_r};
                    OFF_XOFF2:       prdata_r <= {24'h00_0000, xoff2_r};
                    OFF_FIFO_CTRL:   prdata_r <= {24'h00_0000, fcr_r};
                    OFF_INT_STATUS:  prdata_r <= {26'h000_0000, st_rc_r,
                                                  st_xo_r, 4'h0};
                    OFF_FLOW_STATE:  prdata_r <= {26'h000_0000, xoff_sent_r,
                                        cts_stop_r, xoff_stop_r, rts_r,
                                        ten_r, cts_s_r};
                    default:         prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end
    wire rd_isr = PSEL & PENABLE & ~PWRITE & pready_r &
                  (PADDR == OFF_INT_STATUS);

    // ************************************************************
    // CTS synchroniser and edge
    // ************************************************************
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            cts_m_r <= 1'b1; cts_s_r <= 1'b1; cts_d_r <= 1'b1;
        end else begin
            cts_m_r <= CTS_N;
            cts_s_r <= cts_m_r;
            cts_d_r <= cts_s_r;
        end
    end
    wire cts_rise = cts_s_r & ~cts_d_r;

    // ************************************************************
    // RTS output with fill hysteresis
    // ************************************************************
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            rts_hold_r <= 1'b0; rts_r <= 1'b1; rts_d_r <= 1'b1;
        end else begin
            if (!a_rts) rts_hold_r <= 1'b0;
            else if (RX_FILL >= {1'b0, RTS_HI_TH}) rts_hold_r <= 1'b1;
            else if (RX_FILL <= {1'b0, RTS_LO_TH}) rts_hold_r <= 1'b0;
            // Active low, host bit 1 asserts it
            rts_r   <= ~mcr_r[MCR_RTS] | (a_rts & rts_hold_r);
            rts_d_r <= rts_r;
        end
    end
    wire rts_rise = rts_r & ~rts_d_r;

    // ************************************************************
    // Transmit gating, stops only at character end
    // ************************************************************
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            cts_stop_r <= 1'b0; xoff_stop_r <= 1'b0; ten_r <= 1'b1;
            pend_off_r <= 1'b0;
        end else begin
            cts_stop_r <= a_cts & cts_s_r;
            if (hit_off) pend_off_r <= 1'b1;
            else if (TX_CHAR_END | ten_r == 1'b0) pend_off_r <= 1'b0;
            if (hit_off & ~ten_r) xoff_stop_r <= 1'b1;
            else if (pend_off_r & (TX_CHAR_END | ~ten_r)) xoff_stop_r <= 1'b1;
            else if (hit_on & xoff_stop_r) xoff_stop_r <= 1'b0;
            else if (!sw_off) xoff_stop_r <= 1'b0;
            // Stop at stop-bit end, resume at once
            if (ten_r) begin
                if (TX_CHAR_END & (cts_stop_r | pend_off_r)) ten_r <= 1'b0;
                else if (cts_stop_r | xoff_stop_r) ten_r <= TX_CHAR_END ?
                                                          1'b0 : 1'b1;
            end else if (!cts_stop_r & !xoff_stop_r & !pend_off_r) begin
                ten_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Receive path, double-character memory and FIFO write
    // ************************************************************
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            prev_r <= RST_BYTE; prev_on_r <= 1'b0; prev_off_r <= 1'b0;
            rxo_r <= '0;
        end else begin
            if (RX_VALID) begin
                prev_r     <= RX_DATA;
                prev_on_r  <= part_on  & ~hit_on;
                prev_off_r <= part_off & ~hit_off;
            end
            // Flow characters dropped, special kept
            rxo_r.valid <= RX_VALID & ~consume;
            rxo_r.data  <= RX_DATA;
        end
    end

    // ************************************************************
    // Status flags, set wins over read clear
    // ************************************************************
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            st_rc_r <= 1'b0; st_xo_r <= 1'b0; irq_r <= 1'b0;
        end else begin
            if ((rts_rise & ier_r[IER_RTS]) |
                (cts_rise & ier_r[IER_CTS] & a_cts))
                st_rc_r <= 1'b1;
            else if (rd_isr) st_rc_r <= 1'b0;
            if ((hit_off & ier_r[IER_XOFF]) | hit_sp)
                st_xo_r <= 1'b1;
            else if ((hit_on & xoff_stop_r) | rd_isr)
                st_xo_r <= 1'b0;
            irq_r <= st_rc_r | st_xo_r;
        end
    end

    // ************************************************************
    // Automatic Xoff and Xon sending
    // ************************************************************
    logic [4:0] trig, xon_lv;
    always_comb begin
        unique case (fcr_r[1:0])
            2'b00: begin trig = 5'd1;  xon_lv = 5'd0; end
            2'b01: begin trig = 5'd4;  xon_lv = 5'd1; end
            2'b10: begin trig = 5'd8;  xon_lv = 5'd4; end
            2'b11: begin trig = 5'd14; xon_lv = 5'd8; end
        endcase
    end
    wire auto_x = fcr_r[FCR_AUTO_XO] & sw_off;
    wire dbl_tx = dbl_off;

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            snd_r <= SEND_IDLE; snd_xon_r <= 1'b0; xoff_sent_r <= 1'b0;
            dly_r <= 10'd0; txo_r <= '0;
        end else begin
            unique case (snd_r)
                SEND_IDLE: begin
                    if (auto_x & ~xoff_sent_r & RX_FILL >= trig) begin
                        snd_r <= SEND_WAIT;
                        dly_r <= 10'(XOFF_DELAY_CYC - 1);
                    end else if (xoff_sent_r & RX_FILL <= xon_lv) begin
                        snd_r <= SEND_FIRST;
                        snd_xon_r <= 1'b1;
                        txo_r <= '{req: 1'b1, data: on_a};
                    end
                end
                SEND_WAIT: begin
                    if (dly_r == 10'd0) begin
                        snd_r <= SEND_FIRST;
                        snd_xon_r <= 1'b0;
                        txo_r <= '{req: 1'b1, data: off_a};
                    end else dly_r <= dly_r - 10'd1;
                end
                SEND_FIRST: begin
                    if (FC_TX_ACK) begin
                        if ((snd_xon_r ? dbl_on : dbl_tx)) begin
                            snd_r <= SEND_SECND;
                            txo_r <= '{req: 1'b1,
                                       data: snd_xon_r ? xon2_r : xoff2_r};
                        end else begin
                            snd_r <= SEND_IDLE;
                            txo_r <= '0;
                            xoff_sent_r <= ~snd_xon_r;
                        end
                    end
                end
                SEND_SECND: begin
                    if (FC_TX_ACK) begin
                        snd_r <= SEND_IDLE;
                        txo_r <= '0;
                        xoff_sent_r <= ~snd_xon_r;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign PRDATA     = prdata_r;
    assign PREADY     = pready_r;
    assign PSLVERR    = 1'b0;
    assign RTS_N      = rts_r;
    assign FIFO_WR    = rxo_r.valid;
    assign FIFO_WDATA = rxo_r.data;
    assign TX_ENABLE  = ten_r;
    assign FC_TX_REQ  = txo_r.req;
    assign FC_TX_DATA = txo_r.data;
    assign IRQ        = irq_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_rts_auto;
        @(posedge CLK_SYS) disable iff (RESET)
        !a_rts && mcr_r[MCR_RTS] |=> !RTS_N;
    endproperty
    a_rts_auto: assert property (p_rts_auto)
        else $error("RTS raised without auto control");
    property p_rts_hi;
        @(posedge CLK_SYS) disable iff (RESET)
        a_rts && rts_hold_r |=> RTS_N;
    endproperty
    a_rts_hi: assert property (p_rts_hi)
        else $error("RTS not dropped at threshold");
    property p_rts_int;
        @(posedge CLK_SYS) disable iff (RESET)
        rts_rise && ier_r[IER_RTS] |=> st_rc_r ##1 IRQ;
    endproperty
    a_rts_int: assert property (p_rts_int)
        else $error("RTS edge flag missing");
    property p_cts_int;
        @(posedge CLK_SYS) disable iff (RESET)
        cts_rise && ier_r[IER_CTS] && a_cts |=> st_rc_r;
    endproperty
    a_cts_int: assert property (p_cts_int)
        else $error("CTS flag missing");
    property p_cts_stop;
        @(posedge CLK_SYS) disable iff (RESET)
        $fell(TX_ENABLE) |-> $past(TX_CHAR_END);
    endproperty
    a_cts_stop: assert property (p_cts_stop)
        else $error("Transmit stopped mid character");
    property p_loop;
        @(posedge CLK_SYS) disable iff (RESET)
        loop |=> !cts_stop_r;
    endproperty
    a_loop: assert property (p_loop)
        else $error("CTS control in loopback");
    property p_drop;
        @(posedge CLK_SYS) disable iff (RESET)
        consume |=> !FIFO_WR;
    endproperty
    a_drop: assert property (p_drop)
        else $error("Flow character stored");
    property p_xoff_flag;
        @(posedge CLK_SYS) disable iff (RESET)
        hit_off && ier_r[IER_XOFF] |=> st_xo_r;
    endproperty
    a_xoff_flag: assert property (p_xoff_flag)
        else $error("Xoff flag missing");
    property p_delay;
        @(posedge CLK_SYS) disable iff (RESET)
        snd_r == SEND_IDLE ##1 snd_r == SEND_WAIT |->
            !FC_TX_REQ [*8];
    endproperty
    a_delay: assert property (p_delay)
        else $error("Xoff sent too early");
    c_xoff: cover property (@(posedge CLK_SYS) hit_off);
    c_xon:  cover property (@(posedge CLK_SYS) hit_on && xoff_stop_r);
    c_send: cover property (@(posedge CLK_SYS) FC_TX_REQ && FC_TX_ACK);
endmodule // uafc_top
`default_nettype wire

// >>> verif/uafc_remote_model.sv
// Remote UART model on the serial side of the flow control block
`timescale 1ns/10ps
`default_nettype none
module uafc_remote_model (
    input  wire logic       clk,
    input  wire logic       fc_req,
    output logic            cts_n,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            char_end,
    output logic            fc_ack
);
    // Idle state, clear to send is low
    initial begin
        cts_n = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        char_end = 1'b0;
        fc_ack = 1'b0;
    end
    // One received character, junk data outside the pulse
    task automatic send(input logic [7:0] c);
        @(posedge clk) rx_valid <= 1'b1;
        rx_data <= c;
        @(posedge clk) rx_valid <= 1'b0;
        rx_data <= ~c;
    endtask
    // Stop bit of the character on the line
    task automatic stop_bit();
        @(posedge clk) char_end <= 1'b1;
        @(posedge clk) char_end <= 1'b0;
    endtask
    // Pause request toward the block, one means pause
    task automatic hold(input logic v);
        @(posedge clk) cts_n <= v;
    endtask
    // Slow acknowledge of flow character sends
    always @(posedge clk) fc_ack <= fc_req && !fc_ack;
endmodule // uafc_remote_model
`default_nettype wire

// >>> verif/uafc_tb_top.sv
// Testbench of the UART auto flow control block
`timescale 1ns/10ps
`default_nettype none
module uafc_tb_top;
    import uafc_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, cts_n, rxv, ce, req, ack;
    logic rts_n, fwr, txen, irq, slverr;
    logic [7:0]  paddr, rxd, fwd, fcd, lastd;
    logic [31:0] pwdata, prdata, q;
    logic [4:0]  fill;
    logic [3:0]  hi_th, lo_th;
    int n_mismatch, num_checks, nwr, i;
    uafc_top uafc_top_inst (.CLK_SYS(clk), .RESET(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(slverr), .CTS_N(cts_n),
        .RTS_N(rts_n), .RX_VALID(rxv), .RX_DATA(rxd), .FIFO_WR(fwr),
        .FIFO_WDATA(fwd), .RX_FILL(fill), .RTS_HI_TH(hi_th),
        .RTS_LO_TH(lo_th), .TX_CHAR_END(ce), .TX_ENABLE(txen),
        .FC_TX_REQ(req),
        .FC_TX_DATA(fcd), .FC_TX_ACK(ack), .IRQ(irq));
    uafc_remote_model uafc_remote_model_inst (.clk(clk), .fc_req(req),
        .cts_n(cts_n), .rx_valid(rxv), .rx_data(rxd), .char_end(ce),
        .fc_ack(ack));
    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Count writes into the receive FIFO
    always @(posedge clk) if (fwr === 1'b1) begin
        nwr++;
        lastd = fwd;
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One APB transfer, waits for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, fill} = '0;
        hi_th = 4'd8;
        lo_th = 4'd4;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 4; i++) begin
            apb(0, OFF_XON1 + 8'(4 * i), 0);
            chk("xonxoff", q, 0);
        end
        apb(1, OFF_XOFF1, 8'hF3);
        apb(1, OFF_XON1, 8'hF1);
        apb(1, OFF_LINE_CTRL, 0);
        apb(1, OFF_ENH_FEATURE, 8'h15);
        apb(1, OFF_INT_ENABLE, 8'h20);
        uafc_remote_model_inst.send(8'h13);
        uafc_remote_model_inst.stop_bit();
        repeat (4) @(posedge clk);
        chk("xoff txen", txen, 0);
        chk("xoff irq", irq, 1);
        uafc_remote_model_inst.send(8'h11);
        uafc_remote_model_inst.send(8'h41);
        repeat (4) @(posedge clk);
        chk("xon txen", txen, 1);
        chk("xon irq", irq, 0);
        chk("fifo n", nwr, 1);
        chk("fifo d", lastd, 8'h41);
        apb(1, OFF_ENH_FEATURE, 8'h90);
        apb(1, OFF_INT_ENABLE, 8'h80);
        uafc_remote_model_inst.hold(1);
        repeat (6) @(posedge clk);
        chk("cts mid", txen, 1);
        chk("cts irq", irq, 1);
        uafc_remote_model_inst.stop_bit();
        repeat (3) @(posedge clk);
        chk("cts stop", txen, 0);
        uafc_remote_model_inst.hold(0);
        repeat (6) @(posedge clk);
        chk("cts go", txen, 1);
        apb(0, OFF_INT_STATUS, 0);
        chk("status5", q[5], 1);
        apb(1, OFF_ENH_FEATURE, 8'h40);
        apb(1, OFF_MODEM_CTRL, 8'h02);
        repeat (4) @(posedge clk);
        chk("rts on", rts_n, 0);
        hi_th <= 4'd6;
        fill <= 5'd6;
        repeat (4) @(posedge clk);
        chk("rts hi", rts_n, 1);
        fill <= 5'd4;
        repeat (4) @(posedge clk);
        chk("rts lo", rts_n, 0);
        apb(1, OFF_ENH_FEATURE, 8'h05);
        apb(1, OFF_FIFO_CTRL, 8'h04);
        repeat (XOFF_DELAY_CYC + 1) @(posedge clk);
        chk("xoff early", req, 0);
        @(posedge clk);
        chk("xoff req", req, 1);
        chk("xoff char", fcd, 8'hF3);
        fill <= 5'd0;
        repeat (3) @(posedge clk);
        chk("xon req", req, 1);
        chk("xon char", fcd, 8'hF1);
        chk("rts manual", rts_n, 0);
        apb(0, 8'hFC, 0);
        chk("unmapped", q, 0);
        chk("slverr", slverr, 0);
        stop_test();
    end
endmodule // uafc_tb_top
`default_nettype wire
